// *** sgc_pkg.sv ***
`default_nettype none
package sgc_pkg;
    // Core clock
    localparam int CLK_NS         = 40;

    // Timing figures in their own units
    localparam int BLANK_NS       = 240;
    localparam int WINDOW_NS      = 166;
    localparam int OFF_NS         = 21000;
    localparam int SLEEP_PHASE_NS = 1100;
    localparam int CEASE_NS_DEF   = 260000;

    // Cycle counts: least times round up, longest times round down
    localparam int BLANK_CYC      = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int WINDOW_CYC     = (WINDOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int OFF_CYC        = (OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLEEP_PH_CYC   = SLEEP_PHASE_NS / CLK_NS;

    // Counter widths
    localparam int TMR_W          = 10;
    localparam int PH_W           = 16;
    localparam int LFO_W          = 20;
    localparam int PC_W           = 5;
    localparam int SC_W           = 4;

    // Terminal counts at the width of the counters they meet
    localparam logic [TMR_W-1:0] BLANK_END  = TMR_W'(BLANK_CYC - 1);
    localparam logic [TMR_W-1:0] WINDOW_END = TMR_W'(WINDOW_CYC - 1);
    localparam logic [TMR_W-1:0] OFF_END    = TMR_W'(OFF_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO   = 10'h000;
    localparam logic [PH_W-1:0]  SLEEP_PH   = PH_W'(SLEEP_PH_CYC);
    localparam logic [PH_W-1:0]  PH_ZERO    = 16'h0000;
    localparam logic [PH_W-1:0]  PH_MAX     = 16'hFFFF;
    localparam logic [PC_W-1:0]  BURST_PULSES = 5'h10;
    localparam logic [PC_W-1:0]  PC_ZERO    = 5'h00;
    localparam logic [LFO_W-1:0] LFO_ZERO   = 20'h00000;
    // Five burst pulses give ten edges and nine short phases between them
    localparam int SLEEP_PULSES   = 5;
    localparam logic [SC_W-1:0]  SLEEP_EDGES = SC_W'(2 * SLEEP_PULSES - 1);
    localparam logic [SC_W-1:0]  SC_ZERO    = 4'h0;

    // Regulator states, Gray along idle-blank-window-on-off
    typedef enum logic [2:0] {
        SGC_IDLE   = 3'h0,
        SGC_BLANK  = 3'h1,
        SGC_WINDOW = 3'h3,
        SGC_ON     = 3'h2,
        SGC_OFF    = 3'h6
    } sgc_state_t;

    // Current-sense comparator outputs
    typedef struct packed {
        logic peak_limit_comparator;
        logic ccm_window_comparator;
    } sgc_sense_t;

    // Supply lockout conditions
    typedef struct packed {
        logic supply_undervoltage_lockout;
        logic supply_overvoltage_lockout;
    } sgc_lockout_t;
endpackage : sgc_pkg
`default_nettype wire

// *** sgc_sync.sv ***
`default_nettype none
module sgc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    import sgc_pkg::*;

    // Two-stage synchroniser per bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_r <= 1'b0;
                    q[i]   <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    q[i]   <= meta_r;
                end
            end
        end
    endgenerate
endmodule // sgc_sync
`default_nettype wire

// *** sgc_gate_ctrl.sv ***
`default_nettype none
// Notes on behaviour
// RULE1: Secondary controller sends PWM between 20 kHz and 65 kHz while regulating.
// RULE2: Any command-input activity hands gate control to the command input.
// RULE3: No command activity beyond the cease interval returns control to internal regulator.
// RULE4: Cease interval is a settable figure, typically 260 (unit conflicts).
// RULE5: Secondary controller sends five pulses near 500 kHz to request sleep.
// RULE6: On a recognised sleep burst, stop all gate switching and sleep.
// RULE7: Leave sleep on resumed normal pulses or undervoltage lockout.
// RULE8: Each slow-oscillator period enables exactly 16 internal regulator pulses.
// RULE9: Slow-oscillator on-phase enables the gate, remainder disables it, internal mode.
// RULE10: Slow-oscillator period is a configuration input of the block.
// RULE11: Blanking timer masks both comparators at the start of each on-time.
// RULE12: Blanking lasts 240 ns.
// RULE13: After blanking, peak-limit comparator ends the on-time at once.
// RULE14: CCM comparator ends the on-time only inside the post-blanking window.
// RULE15: The post-blanking sensing window lasts 166 ns; the code holds it for WINDOW_CYC, 5 cycles, 200 ns.
// RULE16: Internal mode: fixed 21 us off-time after each on-time, then restart.
// RULE17: Reset or lockout holds gate off and restarts burst count.
// RULE18: Command input and comparators are synchronised before use.
module sgc_gate_ctrl #(
    parameter int CEASE_NS = sgc_pkg::CEASE_NS_DEF
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    pwm_command,
    input  wire sgc_pkg::sgc_sense_t     sense,
    input  wire sgc_pkg::sgc_lockout_t   lockout,
    input  wire logic [sgc_pkg::LFO_W-1:0] slow_burst_period,
    output var  logic                    gate_drive,
    output var  logic                    sleep_mode,
    output var  logic                    external_mode
);
    import sgc_pkg::*;

    localparam logic [PH_W-1:0] CEASE_CYC = PH_W'((CEASE_NS + CLK_NS - 1) / CLK_NS);

    // Decodes the states in which the gate is driven
    function automatic logic on_state(input sgc_state_t st);
        return (st == SGC_BLANK) || (st == SGC_WINDOW) || (st == SGC_ON);
    endfunction

    logic [2:0]       sync_q;
    logic             cmd_s;
    logic             peak_s;
    logic             ccm_s;
    logic             cmd_d_r;
    logic             cmd_edge;
    logic             cmd_rise;
    logic             lock_any;
    logic [PH_W-1:0]  phase_cnt_r;
    logic [SC_W-1:0]  short_cnt_r;
    logic             short_phase;
    logic             sleep_r;
    logic             sleep_nxt;
    logic             ext_mode_r;
    logic             ext_mode_nxt;
    logic             kill_w;
    sgc_state_t       state_r;
    sgc_state_t       state_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmr_nxt;
    logic [LFO_W-1:0] lfo_cnt_r;
    logic [PC_W-1:0]  pulse_cnt_r;
    logic             burst_en;
    logic             lfo_wrap;
    logic             int_start;
    logic             gate_r;

    // Bring command and comparators onto the core clock
    sgc_sync #(.W(3)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({pwm_command, sense.peak_limit_comparator, sense.ccm_window_comparator}),
        .q   (sync_q)
    ); // RULE18

    assign cmd_s    = sync_q[2];
    assign peak_s   = sync_q[1];
    assign ccm_s    = sync_q[0];
    assign lock_any = lockout.supply_undervoltage_lockout | lockout.supply_overvoltage_lockout;

    // Edge detection on the synchronised command
    assign cmd_edge    = cmd_s ^ cmd_d_r;
    assign cmd_rise    = cmd_s & ~cmd_d_r;
    assign short_phase = phase_cnt_r <= SLEEP_PH;

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_d_r <= 1'b0;
        end else begin
            cmd_d_r <= cmd_s;
        end
    end

    // Time since last command edge; saturates so long silence stays long
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_cnt_r <= PH_MAX;
        end else if (cmd_edge) begin
            phase_cnt_r <= PH_ZERO;
        end else if (phase_cnt_r != PH_MAX) begin
            phase_cnt_r <= phase_cnt_r + 16'h0001;
        end
    end

    // Run of consecutive short phases, the sleep burst signature
    always_ff @(posedge clk) begin
        if (rst) begin
            short_cnt_r <= SC_ZERO;
        end else if (cmd_edge) begin
            if (!short_phase) begin
                short_cnt_r <= SC_ZERO;
            end else if (short_cnt_r != SLEEP_EDGES) begin
                short_cnt_r <= short_cnt_r + 4'h1;
            end
        end
    end

    // Sleep entry and wake; a long phase ending in an edge is a normal pulse
    always_comb begin
        sleep_nxt = sleep_r;
        if (sleep_r) begin
            if (lockout.supply_undervoltage_lockout || (cmd_edge && !short_phase)) begin
                sleep_nxt = 1'b0; // RULE7
            end
        end else if (cmd_edge && short_phase && short_cnt_r == SLEEP_EDGES - 4'h1) begin
            sleep_nxt = 1'b1; // RULE6
        end
    end

    // Command source: activity selects external, silence returns internal
    always_comb begin
        ext_mode_nxt = ext_mode_r;
        if (sleep_nxt) begin
            ext_mode_nxt = 1'b0;
        end else if (cmd_edge) begin
            ext_mode_nxt = 1'b1; // RULE2
        end else if (phase_cnt_r >= CEASE_CYC) begin
            ext_mode_nxt = 1'b0; // RULE3 RULE4
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sleep_r    <= 1'b0;
            ext_mode_r <= 1'b0;
        end else begin
            sleep_r    <= sleep_nxt;
            ext_mode_r <= ext_mode_nxt;
        end
    end

    // Any of these ends an on-time and parks the regulator; a source swap
    // aborts too so one pulse never mixes the two command sources
    assign kill_w = lock_any | sleep_r | (ext_mode_nxt != ext_mode_r) | (ext_mode_r & ~cmd_s);

    // Slow oscillator burst window and pulse count
    assign burst_en  = pulse_cnt_r < BURST_PULSES;
    assign lfo_wrap  = lfo_cnt_r >= slow_burst_period - 20'h00001; // RULE10
    assign int_start = !ext_mode_r && state_r == SGC_IDLE && state_nxt == SGC_BLANK;

    always_ff @(posedge clk) begin
        if (rst || lock_any || ext_mode_r) begin
            lfo_cnt_r   <= LFO_ZERO; // RULE17
            pulse_cnt_r <= PC_ZERO;
        end else if (lfo_wrap) begin
            lfo_cnt_r   <= LFO_ZERO;
            pulse_cnt_r <= int_start ? 5'h01 : PC_ZERO;
        end else begin
            lfo_cnt_r   <= lfo_cnt_r + 20'h00001;
            pulse_cnt_r <= pulse_cnt_r + {4'h0, int_start}; // RULE8
        end
    end

    // On/off regulator: blank, window, on, then off-time or wait for command
    always_comb begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r;
        case (state_r)
            SGC_IDLE: begin
                if (ext_mode_r ? cmd_rise : burst_en) begin // RULE9
                    state_nxt = SGC_BLANK;
                    tmr_nxt   = TMR_ZERO;
                end
            end
            SGC_BLANK: begin
                // Comparators are not looked at here
                if (tmr_r == BLANK_END) begin // RULE11 RULE12
                    state_nxt = SGC_WINDOW;
                    tmr_nxt   = TMR_ZERO;
                end else begin
                    tmr_nxt = tmr_r + 10'h001;
                end
            end
            SGC_WINDOW: begin
                if (peak_s || ccm_s) begin // RULE13 RULE14
                    state_nxt = ext_mode_r ? SGC_IDLE : SGC_OFF;
                    tmr_nxt   = TMR_ZERO;
                end else if (tmr_r == WINDOW_END) begin // RULE15
                    state_nxt = SGC_ON;
                end else begin
                    tmr_nxt = tmr_r + 10'h001;
                end
            end
            SGC_ON: begin
                if (peak_s) begin // RULE13
                    state_nxt = ext_mode_r ? SGC_IDLE : SGC_OFF;
                    tmr_nxt   = TMR_ZERO;
                end
            end
            SGC_OFF: begin
                if (tmr_r == OFF_END) begin // RULE16
                    state_nxt = SGC_IDLE;
                end else begin
                    tmr_nxt = tmr_r + 10'h001;
                end
            end
            default: begin
                state_nxt = SGC_IDLE;
                tmr_nxt   = TMR_ZERO;
            end
        endcase
        if (kill_w) begin
            state_nxt = SGC_IDLE; // RULE6 RULE17
            tmr_nxt   = TMR_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= SGC_IDLE;
            tmr_r   <= TMR_ZERO;
        end else begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
        end
    end

    // Gate registered from the next state so it tracks the regulator exactly
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_r <= 1'b0; // RULE17
        end else begin
            gate_r <= on_state(state_nxt);
        end
    end

    assign gate_drive    = gate_r;
    assign sleep_mode    = sleep_r;
    assign external_mode = ext_mode_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence blank_done_s;
        state_r == SGC_BLANK && tmr_r == BLANK_END && !kill_w;
    endsequence
    sequence window_enter_s;
        $rose(state_r == SGC_WINDOW);
    endsequence

    sleep_gate_off_a: assert property (sleep_r |-> !gate_r) // RULE6
        else $error("gate active while asleep");
    lockout_gate_off_a: assert property (lock_any |=> !gate_r && state_r == SGC_IDLE) // RULE17
        else $error("gate active under lockout");
    blank_masks_a: assert property (
        state_r == SGC_BLANK && !kill_w && (peak_s || ccm_s) |=> gate_r) // RULE11
        else $error("comparator ended pulse during blanking");
    blank_length_a: assert property (
        $rose(state_r == SGC_BLANK) ##0 (state_r == SGC_BLANK && !kill_w)[*5]
        |=> state_r == SGC_BLANK) // RULE12
        else $error("blanking shorter than six cycles");
    blank_to_window_a: assert property (blank_done_s |=> state_r == SGC_WINDOW) // RULE12
        else $error("blanking did not open window");
    window_length_a: assert property (
        window_enter_s ##0 (!peak_s && !ccm_s && !kill_w)[*5] |=> state_r == SGC_ON) // RULE15
        else $error("sense window not five cycles");
    peak_end_a: assert property (
        (state_r == SGC_WINDOW || state_r == SGC_ON) && peak_s |=> !gate_r) // RULE13
        else $error("peak limit did not end on-time");
    ccm_end_a: assert property (state_r == SGC_WINDOW && ccm_s |=> !gate_r) // RULE14
        else $error("ccm comparator did not end on-time");
    ccm_ignored_a: assert property (
        state_r == SGC_ON && ccm_s && !peak_s && !kill_w |=> gate_r) // RULE14
        else $error("ccm comparator acted outside window");
    off_time_a: assert property (
        state_r == SGC_OFF && tmr_r != OFF_END && !kill_w |=> state_r == SGC_OFF && !gate_r) // RULE16
        else $error("off-time cut short");
    burst_count_a: assert property (pulse_cnt_r <= BURST_PULSES) // RULE8
        else $error("more than sixteen pulses in one burst");
    burst_gate_a: assert property (
        state_r == SGC_IDLE && !ext_mode_r && !burst_en && !lfo_wrap |=> !gate_r) // RULE9
        else $error("gate outside burst on-phase");
    ext_follow_a: assert property (
        ext_mode_r && cmd_rise && state_r == SGC_IDLE && !kill_w |=> gate_r) // RULE2
        else $error("command rise did not start gate");
    cease_a: assert property (
        !cmd_edge && phase_cnt_r >= CEASE_CYC |=> !ext_mode_r) // RULE3
        else $error("external mode kept past cease time");
    wake_supply_undervoltage_lockout_a: assert property (
        sleep_r && lockout.supply_undervoltage_lockout |=> !sleep_r) // RULE7
        else $error("undervoltage did not wake from sleep");
endmodule // sgc_gate_ctrl
`default_nettype wire

// *** sgc_partner.sv ***
`default_nettype none
// Secondary controller stand-in: PWM while running, sleep burst on request
module sgc_partner #(
    parameter int PER = 500,
    parameter int HI  = 100,
    parameter int BH  = 25
) (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic burst,
    output var  logic pwm_command
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_r = 0;
    int bcnt_r = 0;
    logic burst_hi;

    // 50 kHz period counter, restarts whenever running resumes
    always_ff @(posedge clk) begin
        cnt_r <= (!run || cnt_r == PER - 1) ? 0 : cnt_r + 1;
    end
    // Five pulses of BH high, BH low: near 500 kHz
    always_ff @(posedge clk) begin
        bcnt_r <= burst ? 10 * BH : (bcnt_r > 0 ? bcnt_r - 1 : 0);
    end
    assign burst_hi = bcnt_r > 0 && ((bcnt_r - 1) / BH) % 2 == 1;
    // Registered, so the line only moves just after an edge; idle is low
    always_ff @(posedge clk) begin
        pwm_command <= run ? (cnt_r < HI) : burst_hi;
    end
endmodule // sgc_partner
`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
`define CHK(nm, exp, got) \
    begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s: expected %0d seen %0d", nm, exp, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sgc_pkg::*;
    localparam int PW_PER = 500;
    localparam int PW_HI  = 100;
    localparam int CEASE_C = 1000;
    logic              clk;
    logic              rst;
    logic              run;
    logic              burst;
    logic              pwm_command;
    logic              gate_drive;
    logic              sleep_mode;
    logic              external_mode;
    logic [LFO_W-1:0]  period;
    sgc_sense_t        sense;
    sgc_lockout_t      lockout;
    int                err_total;
    int                checks_done;

    // 25 MHz core clock
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // Short cease count keeps the run brief
    sgc_gate_ctrl #(.CEASE_NS(CEASE_C * CLK_NS)) i_sgc_gate_ctrl (
        .clk(clk), .rst(rst), .pwm_command(pwm_command), .sense(sense),
        .lockout(lockout), .slow_burst_period(period), .gate_drive(gate_drive),
        .sleep_mode(sleep_mode), .external_mode(external_mode));
    sgc_partner #(.PER(PW_PER), .HI(PW_HI)) i_sgc_partner (
        .clk(clk), .run(run), .burst(burst), .pwm_command(pwm_command));

    task automatic conclude;
        $display("mismatches %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic pick(int w);
        return w == 0 ? gate_drive : (w == 1 ? external_mode : sleep_mode);
    endfunction
    // Cycles an output holds a level, sampled on falling edges
    task automatic span(input int w, input logic v, input int lim, output int n);
        n = 0;
        while (pick(w) === v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Bounded wait; a hang counts as a mismatch and ends the run
    task automatic await(input int w, input logic v, input int lim);
        int n;
        span(w, ~v, lim, n);
        if (n >= lim) begin
            err_total++;
            $display("unexpected timeout on output %0d", w);
            conclude;
        end
    endtask
    task automatic rises(input int cyc, output int r);
        logic p;
        r = 0;
        p = gate_drive;
        repeat (cyc) begin
            @(negedge clk);
            if (gate_drive === 1'h1 && p !== 1'h1) r++;
            p = gate_drive;
        end
    endtask

    task automatic t_reset;
        repeat (4) begin
            @(negedge clk);
            `CHK("parked", 3'h0, {gate_drive, sleep_mode, external_mode})
        end
        @(posedge clk);
        rst <= 1'h0;
    endtask
    task automatic t_internal;
        int n;
        await(0, 1'h1, 100);
        @(posedge clk);
        sense.peak_limit_comparator <= 1'h1;
        span(0, 1'h1, 50, n);
        `CHK("blank_len", 1'h1, n >= BLANK_CYC && n <= BLANK_CYC + 2)
        span(0, 1'h0, 700, n);
        `CHK("off_len", 1'h1, n >= OFF_CYC && n <= OFF_CYC + 2)
        await(0, 1'h0, 50);
        @(posedge clk);
        sense.peak_limit_comparator <= 1'h0;
    endtask
    task automatic t_ccm;
        int n;
        await(0, 1'h1, 700);
        repeat (20) @(posedge clk);
        sense.ccm_window_comparator <= 1'h1;
        span(0, 1'h1, 40, n);
        `CHK("ccm_late", 40, n)
        @(posedge clk);
        sense.peak_limit_comparator <= 1'h1;
        await(0, 1'h0, 10);
        @(posedge clk);
        sense.peak_limit_comparator <= 1'h0;
        await(0, 1'h1, 700);
        span(0, 1'h1, 50, n);
        `CHK("ccm_window", 1'h1, n >= BLANK_CYC && n <= BLANK_CYC + 2)
        @(posedge clk);
        sense.ccm_window_comparator <= 1'h0;
    endtask
    task automatic t_burst16;
        int n;
        @(posedge clk);
        lockout.supply_overvoltage_lockout <= 1'h1;
        sense.peak_limit_comparator <= 1'h1;
        repeat (2) @(negedge clk);
        span(0, 1'h0, 20, n);
        `CHK("lockout_hold", 20, n)
        @(posedge clk);
        lockout.supply_overvoltage_lockout <= 1'h0;
        rises(int'(period) - 20, n);
        `CHK("burst_pulses", 16, n)
        rises(2000, n);
        `CHK("next_period", 1'h1, n > 0)
        @(posedge clk);
        sense.peak_limit_comparator <= 1'h0;
    endtask
    task automatic t_external;
        int n;
        int n2;
        int m;
        @(posedge clk);
        run <= 1'h1;
        await(1, 1'h1, 10);
        await(0, 1'h0, 10);
        await(0, 1'h1, 600);
        span(0, 1'h1, 200, n);
        `CHK("follow_high", PW_HI, n)
        await(0, 1'h1, 600);
        span(0, 1'h1, 15, n);
        @(posedge clk);
        sense.peak_limit_comparator <= 1'h1;
        span(0, 1'h1, 200, n2);
        `CHK("ext_term", 1'h1, n2 < 20)
        @(posedge clk);
        sense.peak_limit_comparator <= 1'h0;
        span(0, 1'h0, 600, m);
        `CHK("term_hold", PW_PER, n + n2 + m)
    endtask
    task automatic t_cease;
        int n;
        await(0, 1'h0, 600);
        @(posedge clk);
        run <= 1'h0;
        span(1, 1'h1, 2000, n);
        `CHK("cease_len", 1'h1, n >= CEASE_C && n <= CEASE_C + 8)
        await(0, 1'h1, 700);
    endtask
    task automatic send_burst;
        repeat (40) @(posedge clk);
        burst <= 1'h1;
        @(posedge clk);
        burst <= 1'h0;
        await(2, 1'h1, 300);
    endtask
    task automatic t_sleep;
        int n;
        send_burst;
        `CHK("sleep_ext", 1'h0, external_mode)
        span(0, 1'h0, 1500, n);
        `CHK("sleep_quiet", 1500, n)
        @(posedge clk);
        run <= 1'h1;
        await(1, 1'h1, 10);
        `CHK("wake_pulses", 1'h0, sleep_mode)
        await(0, 1'h1, 600);
        await(0, 1'h0, 200);
        @(posedge clk);
        run <= 1'h0;
        send_burst;
        @(posedge clk);
        lockout.supply_undervoltage_lockout <= 1'h1;
        await(2, 1'h0, 5);
        span(0, 1'h0, 50, n);
        `CHK("uv_hold", 50, n)
        `CHK("uv_ext", 1'h0, external_mode)
        @(posedge clk);
        lockout.supply_undervoltage_lockout <= 1'h0;
        await(0, 1'h1, 700);
    endtask

    // Main sequence
    initial begin
        rst = 1'h1;
        run = 1'h0;
        burst = 1'h0;
        sense = '0;
        lockout = '0;
        period = 20'h02710;
        err_total = 0;
        checks_done = 0;
        t_reset;
        t_internal;
        t_ccm;
        t_burst16;
        t_external;
        t_cease;
        t_sleep;
        conclude;
    end
endmodule // tb_top
`default_nettype wire
